// ---- slot_b_afe_config_regs.sv ----
// Slot B front-end configuration registers and their decoded controls
//
// Overview of operation
// - Four-bit field chooses integration polarity per pulse in a four-pulse group.
// - Bit 0 drives pulse one, bit 1 pulse two, up to bit 3.
// - Pulse index wraps to the first pulse after the fourth.
// - Bit clear gives normal integration order, bit set reverses it.
// - Window width is five bits, one microsecond steps, resets to four.
// - Window start delay is eleven bits, 31.25 ns steps, resets to 0x17.
// - In buffer mode gain codes 00 and 01 mean unity, 10 means 0.7.
// - Buffer-select bit turns integrator into a buffer; resets to zero.
// - Individual gain on: channel 1 from here, channels 2-4 from bits 11:6.
// - Two-bit transimpedance reference select, reset and recommended code 3.
// - Individual gain off: common gain field drives all four channels.
`timescale 1ns/1ps

module slot_b_afe_config_regs #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port from the serial configuration interface
   input wire slot_b_afe_pkg::reg_write_t regWrite,
   input wire logic rdEn,
   input wire logic [ADDR_W-1:0] rdAddr,
   output logic [15:0] rdData,
   output logic rdHit,
   // Per-channel gain register content from the neighbouring block
   input wire logic [15:0] perChannelGainReg,
   // Timing core
   input wire logic pulseStrobe,
   input wire logic slotStart,
   output logic [1:0] pulseIndex,
   output logic pulseReversed,
   output logic [4:0] windowWidthUs,
   output logic [10:0] windowStartDelay,
   // Analog front end
   output slot_b_afe_pkg::settings_t afeSettings,
   output slot_b_afe_pkg::chan_gain_t chanGain,
   output logic bufferGainReduced
);

   // Decoder compares against eight-bit offsets only
   if (ADDR_W != 8) begin : g_bad_addr_w
      $error("ADDR_W must be 8");
   end

   logic [15:0] order_q;
   slot_b_afe_pkg::window_t window_q;
   slot_b_afe_pkg::settings_t settings_q;
   logic [1:0] pulseIdx_q;
   logic [15:0] rdData_q;
   logic rdHit_q;

   // Integration order register; full word kept so it reads back exactly
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         order_q <= {slot_b_afe_pkg::ORDER_UPPER_RST,
                     slot_b_afe_pkg::ORDER_RST};
      end else if (regWrite.wrEn &&
                   regWrite.addr == slot_b_afe_pkg::ORDER_ADDR) begin
         order_q <= regWrite.wrData;
      end
   end

   // Integration window register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         window_q.windowWidthUs <= slot_b_afe_pkg::WIDTH_RST;
         window_q.windowStartDelay <= slot_b_afe_pkg::DELAY_RST;
      end else if (regWrite.wrEn &&
                   regWrite.addr == slot_b_afe_pkg::WINDOW_ADDR) begin
         window_q <= regWrite.wrData;
      end
   end

   // Front-end settings register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         settings_q.analogModeCode <= slot_b_afe_pkg::MODE_RST;
         settings_q.integratorGainCode <= slot_b_afe_pkg::INTGAIN_RST;
         settings_q.integratorBufferSelect <=
            slot_b_afe_pkg::BUFSEL_RST;
         settings_q.perChannelGainEnable <= slot_b_afe_pkg::INDEN_RST;
         settings_q.transimpedanceRefSelect <=
            slot_b_afe_pkg::VREF_RST;
         settings_q.reservedBits <= slot_b_afe_pkg::RSVD_RST;
         settings_q.commonTransimpedanceGain <= slot_b_afe_pkg::TIAGAIN_RST;
      end else if (regWrite.wrEn &&
                   regWrite.addr == slot_b_afe_pkg::SETTINGS_ADDR) begin
         // Reserved values are stored as written; host keeps them legal
         settings_q <= regWrite.wrData;
      end
   end

   // Pulse index within the four-pulse group, restarted at each slot
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pulseIdx_q <= 2'h0;
      end else if (slotStart) begin
         pulseIdx_q <= 2'h0;
      end else if (pulseStrobe) begin
         // Two-bit counter wraps from the fourth pulse to the first
         pulseIdx_q <= pulseIdx_q + 2'h1;
      end
   end

   assign pulseIndex = pulseIdx_q;
   // Index selects its own order bit; one means reversed sequence
   assign pulseReversed = order_q[slot_b_afe_pkg::ORDER_LSB +
                                  pulseIdx_q];

   assign windowWidthUs = window_q.windowWidthUs;
   assign windowStartDelay = window_q.windowStartDelay;
   assign afeSettings = settings_q;

   // Only meaningful with buffer select set, which host limits to TIA-ADC
   assign bufferGainReduced = settings_q.integratorBufferSelect &&
      settings_q.integratorGainCode ==
      slot_b_afe_pkg::BUFGAIN_07_CODE;

   // Channel gain routing
   always_comb begin
      chanGain.ch1 = settings_q.commonTransimpedanceGain;
      if (settings_q.perChannelGainEnable) begin
         chanGain.ch2 = perChannelGainReg[slot_b_afe_pkg::PERCH_LSB +: 2];
         chanGain.ch3 =
            perChannelGainReg[slot_b_afe_pkg::PERCH_LSB + 2 +: 2];
         chanGain.ch4 =
            perChannelGainReg[slot_b_afe_pkg::PERCH_LSB + 4 +: 2];
      end else begin
         chanGain.ch2 = settings_q.commonTransimpedanceGain;
         chanGain.ch3 = settings_q.commonTransimpedanceGain;
         chanGain.ch4 = settings_q.commonTransimpedanceGain;
      end
   end

   // Registered read-back, one cycle after the request
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdData_q <= 16'h0000;
         rdHit_q <= 1'b0;
      end else if (rdEn) begin
         if (rdAddr == slot_b_afe_pkg::ORDER_ADDR) begin
            rdData_q <= order_q;
            rdHit_q <= 1'b1;
         end else if (rdAddr == slot_b_afe_pkg::WINDOW_ADDR) begin
            rdData_q <= window_q;
            rdHit_q <= 1'b1;
         end else if (rdAddr == slot_b_afe_pkg::SETTINGS_ADDR) begin
            rdData_q <= settings_q;
            rdHit_q <= 1'b1;
         end else begin
            // Other addresses belong to neighbouring blocks
            rdData_q <= 16'h0000;
            rdHit_q <= 1'b0;
         end
      end else begin
         rdHit_q <= 1'b0;
      end
   end

   assign rdData = rdData_q;
   assign rdHit = rdHit_q;

endmodule : slot_b_afe_config_regs

// ---- slot_b_afe_pkg.sv ----
// Offsets, field layouts and reset values of the slot B front-end registers
package slot_b_afe_pkg;

   // Register offsets (word address on the configuration port)
   localparam logic [7:0] ORDER_ADDR = 8'h1d;
   localparam logic [7:0] WINDOW_ADDR = 8'h3b;
   localparam logic [7:0] SETTINGS_ADDR = 8'h44;

   // Integration order register
   localparam int ORDER_LSB = 0;
   localparam int ORDER_W = 4;
   localparam logic [3:0] ORDER_RST = 4'h0;
   localparam logic [11:0] ORDER_UPPER_RST = 12'h000;

   // Integration window register
   localparam int WIDTH_LSB = 11;
   localparam int WIDTH_W = 5;
   localparam logic [4:0] WIDTH_RST = 5'h04;
   localparam int DELAY_LSB = 0;
   localparam int DELAY_W = 11;
   localparam logic [10:0] DELAY_RST = 11'h017;
   localparam real WIDTH_UNIT_NS = 1000.0;
   localparam real DELAY_UNIT_NS = 31.25;

   // Front-end settings register
   localparam int MODE_LSB = 10;
   localparam logic [5:0] MODE_RST = 6'h07;
   localparam int INTGAIN_LSB = 8;
   localparam logic [1:0] INTGAIN_RST = 2'h0;
   localparam int BUFSEL_BIT = 7;
   localparam logic BUFSEL_RST = 1'b0;
   localparam int INDEN_BIT = 6;
   localparam logic INDEN_RST = 1'b0;
   localparam int VREF_LSB = 4;
   localparam logic [1:0] VREF_RST = 2'h3;
   localparam int RSVD_LSB = 2;
   localparam logic [1:0] RSVD_RST = 2'h2;
   localparam int TIAGAIN_LSB = 0;
   localparam logic [1:0] TIAGAIN_RST = 2'h0;

   // Per-channel gain register fields used for channels 2 to 4
   localparam int PERCH_LSB = 6;

   // Integrator-as-buffer gain codes
   localparam logic [1:0] BUFGAIN_07_CODE = 2'h2;

   typedef struct packed {
      logic [5:0] analogModeCode;
      logic [1:0] integratorGainCode;
      logic integratorBufferSelect;
      logic perChannelGainEnable;
      logic [1:0] transimpedanceRefSelect;
      logic [1:0] reservedBits;
      logic [1:0] commonTransimpedanceGain;
   } settings_t;

   typedef struct packed {
      logic [4:0] windowWidthUs;
      logic [10:0] windowStartDelay;
   } window_t;

   typedef struct packed {
      logic [1:0] ch4;
      logic [1:0] ch3;
      logic [1:0] ch2;
      logic [1:0] ch1;
   } chan_gain_t;

   typedef struct packed {
      logic wrEn;
      logic [7:0] addr;
      logic [15:0] wrData;
   } reg_write_t;

endpackage : slot_b_afe_pkg

// ---- slot_b_afe_config_regs_chk.sv ----
// Port-level assertions for the slot B front-end register block
`timescale 1ns/1ps
module slot_b_afe_config_regs_chk #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Watched ports
   input wire slot_b_afe_pkg::reg_write_t regWrite,
   input wire logic rdEn,
   input wire logic [ADDR_W-1:0] rdAddr,
   input wire logic [15:0] rdData,
   input wire logic rdHit,
   input wire logic [15:0] perChannelGainReg,
   input wire logic pulseStrobe,
   input wire logic slotStart,
   input wire logic [1:0] pulseIndex,
   input wire logic pulseReversed,
   input wire logic [4:0] windowWidthUs,
   input wire logic [10:0] windowStartDelay,
   input wire slot_b_afe_pkg::settings_t afeSettings,
   input wire slot_b_afe_pkg::chan_gain_t chanGain,
   input wire logic bufferGainReduced
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire wrWin = regWrite.wrEn && regWrite.addr == 8'h3b;
   wire wrSet = regWrite.wrEn && regWrite.addr == 8'h44;
   property p_start; slotStart |=> pulseIndex == 2'h0; endproperty
   a_start: assert property (p_start) else $error("index not cleared");
   property p_step;
      pulseStrobe && !slotStart |=> pulseIndex == $past(pulseIndex) + 2'h1;
   endproperty
   a_step: assert property (p_step) else $error("index step");
   property p_win;
      wrWin |=> {windowWidthUs, windowStartDelay} == $past(regWrite.wrData);
   endproperty
   a_win: assert property (p_win) else $error("window write");
   property p_set; wrSet |=> afeSettings == $past(regWrite.wrData); endproperty
   a_set: assert property (p_set) else $error("settings write");
   property p_hold; !wrSet |=> $stable(afeSettings); endproperty
   a_hold: assert property (p_hold) else $error("settings drift");
   property p_buf;
      bufferGainReduced == (afeSettings[7] && afeSettings[9:8] == 2'h2);
   endproperty
   a_buf: assert property (p_buf) else $error("buffer gain");
   property p_gain; chanGain == (afeSettings[6] ?
      {perChannelGainReg[11:6], afeSettings[1:0]} : {4{afeSettings[1:0]}});
   endproperty
   a_gain: assert property (p_gain) else $error("gain map");
   property p_rd; rdEn && rdAddr == 8'h3b |=> rdHit &&
      rdData == {$past(windowWidthUs), $past(windowStartDelay)};
   endproperty
   a_rd: assert property (p_rd) else $error("window read");
endmodule : slot_b_afe_config_regs_chk
bind slot_b_afe_config_regs slot_b_afe_config_regs_chk #(.ADDR_W(ADDR_W))
   u_slot_b_afe_config_regs_chk (.*);

// ---- host_model.sv ----
// Host side of the configuration port: register writes and reads
`timescale 1ns/1ps
module host_model (
   // Clock
   input wire logic clk,
   // Configuration port
   output slot_b_afe_pkg::reg_write_t regWrite,
   output logic rdEn,
   output logic [7:0] rdAddr,
   input wire logic [15:0] rdData,
   input wire logic rdHit
);
   logic tiaAdc = 1'b0;
   initial begin
      regWrite = '0;
      rdEn = 1'b0;
      rdAddr = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d,
      output logic [15:0] sent);
      if (a == 8'h1d) d[15:4] = 12'h000;
      if (a == 8'h44) begin
         d[15:10] = 6'h07;
         d[3:2] = 2'h1;
         if (!tiaAdc) d[7] = 1'b0;
      end
      sent = d;
      @(posedge clk);
      regWrite <= '{1'b1, a, d};
      @(posedge clk);
      // Released lines must not keep the last value
      regWrite <= '{1'b0, ~a, ~d};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d,
      output logic hit);
      @(posedge clk);
      rdEn <= 1'b1;
      rdAddr <= a;
      @(posedge clk);
      rdEn <= 1'b0;
      rdAddr <= ~a;
      #1;
      d = rdData;
      hit = rdHit;
   endtask : rd
endmodule : host_model

// ---- slot_b_afe_config_regs_tb.sv ----
// Randomised self-checking bench for the slot B front-end registers
`timescale 1ns/1ps
module slot_b_afe_config_regs_tb;
   logic clk, resetn, rdEn, rdHit, pulseStrobe, slotStart, pulseReversed;
   logic bufferGainReduced, h;
   logic [1:0] pulseIndex;
   logic [4:0] windowWidthUs;
   logic [10:0] windowStartDelay;
   logic [7:0] rdAddr;
   logic [15:0] rdData, perChannelGainReg, v, s, w;
   slot_b_afe_pkg::reg_write_t regWrite;
   slot_b_afe_pkg::settings_t afeSettings;
   slot_b_afe_pkg::chan_gain_t chanGain;
   logic [7:0] ad [3] = '{8'h1d, 8'h3b, 8'h44};
   logic [15:0] rs [3] = '{16'h0000, 16'h2017, 16'h1c38};
   int bad_count = 0, num_checks = 0, seed = 26;
   host_model u_host (.*);
   slot_b_afe_config_regs u_slot_b_afe_config_regs (.*);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   function automatic logic [7:0] gain_exp(logic [15:0] st, logic [15:0] pc);
      return st[6] ? {pc[11:6], st[1:0]} : {4{st[1:0]}};
   endfunction : gain_exp
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   initial begin
      #100000;
      bad_count++;
      complete_run();
   end
   initial begin
      resetn = 1'b0;
      perChannelGainReg = 16'h0000;
      pulseStrobe = 1'b0;
      slotStart = 1'b0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         u_host.rd(i < 3 ? ad[i] : 8'h45, v, h);
         chk("reset value", i < 3 ? rs[i] : 16'h0000, v);
         chk("read hit", i < 3, h);
      end
      for (int i = 0; i < 24; i++) begin
         // Fixed case forces buffer mode with the reduced gain code
         v = (i == 2) ? 16'h02c0 : $random(seed);
         u_host.tiaAdc = v[0] | (i == 2);
         @(posedge clk) perChannelGainReg <= $random(seed);
         u_host.wr(ad[i % 3], v, s);
         u_host.rd(ad[i % 3], w, h);
         chk("readback", s, w);
         if (i % 3 == 1) begin
            chk("window", s, {windowWidthUs, windowStartDelay});
         end
         if (i % 3 == 2) begin
            chk("chanGain", gain_exp(s, perChannelGainReg), chanGain);
            chk("afeSettings", s, afeSettings);
            chk("bufGain", s[7] && s[9:8] == 2'h2, bufferGainReduced);
         end
         if (i % 3 == 0) begin
            @(posedge clk) slotStart <= 1'b1;
            @(posedge clk) slotStart <= 1'b0;
            pulseStrobe <= 1'b1;
            for (int k = 0; k < 7; k++) begin
               #1;
               chk("index", k % 4, pulseIndex);
               chk("polarity", s[k % 4], pulseReversed);
               @(posedge clk);
            end
            pulseStrobe <= 1'b0;
         end
      end
      complete_run();
   end
endmodule : slot_b_afe_config_regs_tb
